// ### design/jack_detect_regs.svh
/*
  Register indices, byte addresses, field positions and reset values
  of the jack insertion detect block.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
`ifndef JACK_DETECT_REGS_SVH
`define JACK_DETECT_REGS_SVH

// register indices as printed, byte address is index times four
`define JD_IDX_ENABLE      16'h02D3
`define JD_IDX_STATUS_ONE  16'h1886
`define JD_IDX_STATUS_TWO  16'h1986
`define JD_IDX_DEBOUNCE    16'h1A06
`define JD_IDX_EDGE_MASK   16'h1A86
`define JD_IDX_SHIFT       2

// field positions
`define JD_EN_A_BIT        0
`define JD_EN_B_BIT        1
`define JD_STS_A_BIT       0
`define JD_STS_B_BIT       2
`define JD_DB_A_BIT        0
`define JD_DB_B_BIT        2
`define JD_MASK_RISE_A_BIT 0
`define JD_MASK_RISE_B_BIT 1
`define JD_MASK_FALL_A_BIT 2
`define JD_MASK_FALL_B_BIT 3

// reset values and default debounce length in slow ticks
`define JD_PIN_IDLE        1'h1
`define JD_BIT_RST         1'h0
`define JD_WORD_RST        32'h0000_0000
`define JD_DB_TICKS        4

`endif

// ### design/jack_detect_pkg.sv
/*
  Types shared by the jack insertion detect block.
  Assumes the constants header is included by the modules.
*/
package jack_detect_pkg;

  // one bit per jack input
  typedef struct packed {
    logic b;
    logic a;
  } jack_pair_t;

  // per-input edge masks
  typedef struct packed {
    jack_pair_t fall;
    jack_pair_t rise;
  } edge_mask_t;

  // debounce filter states
  typedef enum logic [0:0] {
    FILT_STABLE,
    FILT_WAIT
  } filt_mode_t;

  // whole state of the top module
  typedef struct packed {
    jack_pair_t  sync_first;
    jack_pair_t  sync_second;
    logic        slow_prev;
    jack_pair_t  enable;
    jack_pair_t  filter_sel;
    edge_mask_t  mask;
    jack_pair_t  present;
    logic        event_out;
    logic [31:0] rdata;
    logic        slverr;
  } jd_state_t;

endpackage : jack_detect_pkg

// ### design/jack_debounce.sv
/*
  Debounce filter for one synchronised jack input.
  Assumes tick is a one-cycle pulse per 32 kHz period and sample
  is already synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none

`include "jack_detect_regs.svh"

module jack_debounce
  import jack_detect_pkg::*;
#(
  parameter int   TICKS   = `JD_DB_TICKS,
  parameter logic RST_LVL = `JD_PIN_IDLE
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sample,
  input  wire logic tick,
  input  wire logic filter_on,
  output logic      filtered
);

  localparam int CW = $clog2(TICKS + 1);

  typedef struct packed {
    filt_mode_t    mode;
    logic [CW-1:0] cnt;
    logic          level;
  } db_state_t;

  db_state_t st_reg;
  db_state_t st_next;

  // ----------------------------------------------------------------
  // filter next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (!filter_on) begin
      st_next.mode  = FILT_STABLE;
      st_next.cnt   = '0;
      st_next.level = sample;
    end else begin
      case (st_reg.mode)
        FILT_STABLE: begin
          if (sample != st_reg.level) begin
            st_next.mode = FILT_WAIT;
            st_next.cnt  = '0;
          end
        end
        FILT_WAIT: begin
          if (sample == st_reg.level) begin
            st_next.mode = FILT_STABLE;          // bounce, restart
          end else if (tick) begin
            if (st_reg.cnt == CW'(TICKS - 1)) begin
              st_next.level = sample;
              st_next.mode  = FILT_STABLE;
            end else begin
              st_next.cnt = st_reg.cnt + CW'(1);
            end
          end
        end
        default: begin
          st_next.mode = FILT_STABLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.mode  <= FILT_STABLE;
      st_reg.cnt   <= '0;
      st_reg.level <= RST_LVL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign filtered = st_reg.level;

endmodule : jack_debounce

`default_nettype wire

// ### design/jack_insertion_detect.sv
/*
  Jack insertion detect: two switch-contact inputs, per-input enable
  and debounce, duplicated status of the detected levels, masked insertion and removal
  events, and detected levels for the clamp logic. APB slave.
  Assumes jack pins idle high and are pulled low by the socket switch,
  slow_clk_in is the 32 kHz clock seen as a level, and sleep_mode
  comes from the device power controller.
*/
`timescale 1ns/10ps
`default_nettype none

`include "jack_detect_regs.svh"

module jack_insertion_detect
  import jack_detect_pkg::*;
#(
  parameter int ADDR_W   = 16,
  parameter int DB_TICKS = `JD_DB_TICKS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              jack_sense_pin_a,
  input  wire logic              jack_sense_pin_b,
  input  wire logic              slow_clk_in,
  input  wire logic              sleep_mode,
  output logic                   jack_present_a,
  output logic                   jack_present_b,
  output logic                   jack_event
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // true when the bus address selects the register at this index
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [15:0]       idx
  );
    logic [ADDR_W-1:0] want;
    want    = ADDR_W'({idx, 2'h0});
    reg_hit = (addr == want);
  endfunction : reg_hit

  // true when the address matches any mapped register
  function automatic logic any_hit(
    input logic [ADDR_W-1:0] addr
  );
    any_hit = reg_hit(addr, `JD_IDX_ENABLE)
            | reg_hit(addr, `JD_IDX_STATUS_ONE)
            | reg_hit(addr, `JD_IDX_STATUS_TWO)
            | reg_hit(addr, `JD_IDX_DEBOUNCE)
            | reg_hit(addr, `JD_IDX_EDGE_MASK);
  endfunction : any_hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------

  jd_state_t  st_reg;
  jd_state_t  st_next;
  jack_pair_t filtered;
  jack_pair_t filter_on;
  jack_pair_t pins;
  jack_pair_t present_now;
  jack_pair_t rise_ev;
  jack_pair_t fall_ev;
  logic       slow_tick;
  logic       setup_phase;
  logic       write_access;
  logic [31:0] status_word;

  // bus phase qualifiers
  assign setup_phase  = psel & ~penable;
  assign write_access = psel & penable & pwrite;

  // zero wait state: read data was captured in the setup cycle
  assign pready = psel & penable;

  // pins gathered into one carrier
  assign pins.a = jack_sense_pin_a;
  assign pins.b = jack_sense_pin_b;

  // one pulse per rising edge of the slow clock
  assign slow_tick = slow_clk_in & ~st_reg.slow_prev;

  // ----------------------------------------------------------------
  // debounce filters
  // ----------------------------------------------------------------

  // sleep bypasses the filter whatever the select bits say
  assign filter_on.a = st_reg.filter_sel.a & ~sleep_mode;
  assign filter_on.b = st_reg.filter_sel.b & ~sleep_mode;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_filt
      jack_debounce #(
        .TICKS   (DB_TICKS),
        .RST_LVL (`JD_PIN_IDLE)
      ) u_db (
        .pclk      (pclk),
        .presetn   (presetn),
        .sample    (st_reg.sync_second[i]),
        .tick      (slow_tick),
        .filter_on (filter_on[i]),
        .filtered  (filtered[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // detection and edge events
  // ----------------------------------------------------------------

  // low pin means a jack is in; disabled inputs read as absent
  always_comb begin
    present_now.a = st_reg.enable.a & ~filtered.a;
    present_now.b = st_reg.enable.b & ~filtered.b;
  end

  // insertion is a rise, removal a fall, while the input stays enabled
  always_comb begin
    rise_ev = present_now & ~st_reg.present & st_reg.enable;
    fall_ev = ~present_now & st_reg.present & st_reg.enable;
  end

  // status word, both copies built from the same bits
  always_comb begin
    status_word                = `JD_WORD_RST;
    status_word[`JD_STS_A_BIT] = st_reg.present.a;
    status_word[`JD_STS_B_BIT] = st_reg.present.b;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // two-stage synchroniser, first stage feeds only the second
    st_next.sync_first  = pins;
    st_next.sync_second = st_reg.sync_first;

    // slow clock edge history
    st_next.slow_prev = slow_clk_in;

    // detected levels
    st_next.present = present_now;

    // masked events, not gated by sleep so they can wake the device
    st_next.event_out = |((rise_ev & st_reg.mask.rise)
                        | (fall_ev & st_reg.mask.fall));

    // register writes take effect at the access edge
    if (write_access) begin
      if (reg_hit(paddr, `JD_IDX_ENABLE)) begin
        st_next.enable.a = pwdata[`JD_EN_A_BIT];
        st_next.enable.b = pwdata[`JD_EN_B_BIT];
        // status follows a new enable at once, so enabling is no event
        st_next.present.a = pwdata[`JD_EN_A_BIT] & ~filtered.a;
        st_next.present.b = pwdata[`JD_EN_B_BIT] & ~filtered.b;
      end
      if (reg_hit(paddr, `JD_IDX_DEBOUNCE)) begin
        st_next.filter_sel.a = pwdata[`JD_DB_A_BIT];
        st_next.filter_sel.b = pwdata[`JD_DB_B_BIT];
      end
      if (reg_hit(paddr, `JD_IDX_EDGE_MASK)) begin
        st_next.mask.rise.a = pwdata[`JD_MASK_RISE_A_BIT];
        st_next.mask.rise.b = pwdata[`JD_MASK_RISE_B_BIT];
        st_next.mask.fall.a = pwdata[`JD_MASK_FALL_A_BIT];
        st_next.mask.fall.b = pwdata[`JD_MASK_FALL_B_BIT];
      end
    end

    // read data and error captured in the setup cycle
    if (setup_phase) begin
      st_next.rdata  = `JD_WORD_RST;
      st_next.slverr = ~any_hit(paddr);
      if (!pwrite) begin
        if (reg_hit(paddr, `JD_IDX_ENABLE)) begin
          st_next.rdata[`JD_EN_A_BIT] = st_reg.enable.a;
          st_next.rdata[`JD_EN_B_BIT] = st_reg.enable.b;
        end
        if (reg_hit(paddr, `JD_IDX_STATUS_ONE)) begin
          st_next.rdata = status_word;
        end
        if (reg_hit(paddr, `JD_IDX_STATUS_TWO)) begin
          st_next.rdata = status_word;
        end
        if (reg_hit(paddr, `JD_IDX_DEBOUNCE)) begin
          st_next.rdata[`JD_DB_A_BIT] = st_reg.filter_sel.a;
          st_next.rdata[`JD_DB_B_BIT] = st_reg.filter_sel.b;
        end
        if (reg_hit(paddr, `JD_IDX_EDGE_MASK)) begin
          st_next.rdata[`JD_MASK_RISE_A_BIT] = st_reg.mask.rise.a;
          st_next.rdata[`JD_MASK_RISE_B_BIT] = st_reg.mask.rise.b;
          st_next.rdata[`JD_MASK_FALL_A_BIT] = st_reg.mask.fall.a;
          st_next.rdata[`JD_MASK_FALL_B_BIT] = st_reg.mask.fall.b;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.sync_first  <= '{b: `JD_PIN_IDLE, a: `JD_PIN_IDLE};
      st_reg.sync_second <= '{b: `JD_PIN_IDLE, a: `JD_PIN_IDLE};
      st_reg.slow_prev   <= `JD_BIT_RST;
      st_reg.enable      <= '{b: `JD_BIT_RST, a: `JD_BIT_RST};
      st_reg.filter_sel  <= '{b: `JD_BIT_RST, a: `JD_BIT_RST};
      st_reg.mask        <= '0;
      st_reg.present     <= '{b: `JD_BIT_RST, a: `JD_BIT_RST};
      st_reg.event_out   <= `JD_BIT_RST;
      st_reg.rdata       <= `JD_WORD_RST;
      st_reg.slverr      <= `JD_BIT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // detected levels for the clamp logic
  assign jack_present_a = st_reg.present.a;
  assign jack_present_b = st_reg.present.b;

  // masked event pulse to the device interrupt controller
  assign jack_event = st_reg.event_out;

  // bus answers; error only shows during the access phase
  assign prdata  = st_reg.rdata;
  assign pslverr = st_reg.slverr & psel & penable;

endmodule : jack_insertion_detect

`default_nettype wire

// ### sim/jack_detect_sva.sv
/* checker for the jack detect block, bound to its top module
   assumes zero wait state apb and registered jack outputs */
`timescale 1ns/10ps
`default_nettype none
`include "jack_detect_regs.svh"
module jack_detect_sva #(
  parameter int ADDR_W   = 16,
  parameter int DB_TICKS = 4
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              jack_sense_pin_a,
  input wire logic              jack_sense_pin_b,
  input wire logic              jack_present_a,
  input wire logic              jack_present_b,
  input wire logic              jack_event
);
  localparam logic [ADDR_W-1:0] EN = ADDR_W'(`JD_IDX_ENABLE << `JD_IDX_SHIFT);
  localparam logic [ADDR_W-1:0] S1 = ADDR_W'(`JD_IDX_STATUS_ONE << `JD_IDX_SHIFT);
  localparam logic [ADDR_W-1:0] S2 = ADDR_W'(`JD_IDX_STATUS_TWO << `JD_IDX_SHIFT);
  localparam logic [ADDR_W-1:0] DB = ADDR_W'(`JD_IDX_DEBOUNCE << `JD_IDX_SHIFT);
  localparam logic [ADDR_W-1:0] MK = ADDR_W'(`JD_IDX_EDGE_MASK << `JD_IDX_SHIFT);
  logic mapped;
  logic setup;
  logic rd_acc;

  // ----------------
  // assertions
  // ----------------
  // decode helpers for the properties
  assign mapped = paddr inside {EN, S1, S2, DB, MK};
  assign setup  = psel && !penable;
  assign rd_acc = psel && penable && !pwrite;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  AST_UNMAPPED: assert property (rd_acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  AST_HOLD: assert property ($changed(prdata) |-> $past(setup))
    else $error("read data moved outside setup");
  AST_STS_ONE: assert property (rd_acc && paddr == S1 |->
    prdata[0] == $past(jack_present_a) && prdata[2] == $past(jack_present_b))
    else $error("status copy one wrong");
  AST_STS_TWO: assert property (rd_acc && paddr == S2 |->
    prdata[0] == $past(jack_present_a) && prdata[2] == $past(jack_present_b))
    else $error("status copy two wrong");
  AST_RISE_A: assert property ($rose(jack_present_a) |-> !$past(jack_sense_pin_a, 4))
    else $error("jack a detected without low pin");
  AST_RISE_B: assert property ($rose(jack_present_b) |-> !$past(jack_sense_pin_b, 4))
    else $error("jack b detected without low pin");
  AST_EVENT: assert property (jack_event |->
    jack_present_a != $past(jack_present_a) ||
    jack_present_b != $past(jack_present_b))
    else $error("event without status change");

  // main scenarios reached
  cover property (jack_event);
  cover property (rd_acc && !mapped);
  cover property ($rose(jack_present_b));
endmodule : jack_detect_sva

bind jack_insertion_detect jack_detect_sva #(.ADDR_W(ADDR_W), .DB_TICKS(DB_TICKS)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .jack_sense_pin_a(jack_sense_pin_a), .jack_sense_pin_b(jack_sense_pin_b),
  .jack_present_a(jack_present_a), .jack_present_b(jack_present_b),
  .jack_event(jack_event));
`default_nettype wire

// ### sim/jack_socket_model.sv
/* jack socket switch contacts, pulled high while open
   assumes plug and bounce commands change at rising edges */
`timescale 1ns/10ps
`default_nettype none
module jack_socket_model (
  input  wire logic pclk,
  input  wire logic plug_a,
  input  wire logic plug_b,
  input  wire logic bounce,
  output var logic  pin_a,
  output var logic  pin_b
);
  // ----------------
  // contacts
  // ----------------
  // open contacts idle at the pull-up level
  initial begin
    pin_a = 1'b1;
    pin_b = 1'b1;
  end

  // seated plug grounds the contact, chatter toggles contact a only
  always @(posedge pclk) begin
    pin_a <= bounce ? ~pin_a : ~plug_a;
    pin_b <= ~plug_b;
  end
endmodule : jack_socket_model
`default_nettype wire

// ### sim/jack_insertion_detect_tb.sv
/* directed bench for the jack detect block over apb
   assumes the socket model and the bound checker */
`timescale 1ns/10ps
`default_nettype none
`include "jack_detect_regs.svh"
module jack_insertion_detect_tb;
  localparam logic [15:0] EN  = `JD_IDX_ENABLE << `JD_IDX_SHIFT;
  localparam logic [15:0] S1  = `JD_IDX_STATUS_ONE << `JD_IDX_SHIFT;
  localparam logic [15:0] S2  = `JD_IDX_STATUS_TWO << `JD_IDX_SHIFT;
  localparam logic [15:0] DB  = `JD_IDX_DEBOUNCE << `JD_IDX_SHIFT;
  localparam logic [15:0] MK  = `JD_IDX_EDGE_MASK << `JD_IDX_SHIFT;
  localparam logic [15:0] ALL [5] = '{EN, S1, S2, DB, MK};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, err, pin_a, pin_b, pres_a, pres_b, jack_event;
  logic        slow_clk = 1'b0, sleep = 1'b0, plug_a = 1'b0, plug_b = 1'b0, bounce = 1'b0;
  int          slow_cnt = 0, tests_run = 0, bad_count = 0;

  // ----------------
  // environment
  // ----------------
  always #5 pclk = ~pclk;

  // roughly 32 kHz slow clock from the bus clock
  always @(posedge pclk) begin
    slow_cnt <= (slow_cnt == 1562) ? 0 : slow_cnt + 1;
    if (slow_cnt == 1562) slow_clk <= ~slow_clk;
  end

  jack_insertion_detect #(.DB_TICKS(2)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .jack_sense_pin_a(pin_a), .jack_sense_pin_b(pin_b), .slow_clk_in(slow_clk),
    .sleep_mode(sleep), .jack_present_a(pres_a), .jack_present_b(pres_b),
    .jack_event(jack_event));

  jack_socket_model socket (
    .pclk(pclk), .plug_a(plug_a), .plug_b(plug_b), .bounce(bounce),
    .pin_a(pin_a), .pin_b(pin_b));

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      check("pready", 32'h0, 32'h1);
      final_report();
    end
  endtask : apb

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check("register", q, exp);
  endtask : rd

  task automatic plug(input logic a, input logic b, input logic bn);
    @(posedge pclk);
    plug_a <= a;
    plug_b <= b;
    bounce <= bn;
  endtask : plug

  // bounded watch for an event pulse
  task automatic wait_ev(input int lim, input logic exp);
    logic hit;
    hit = 1'b0;
    repeat (lim) begin
      @(negedge pclk);
      if (jack_event === 1'b1) hit = 1'b1;
      if (hit) break;
    end
    check("event", {31'h0, hit}, {31'h0, exp});
    if (exp && !hit) final_report();
  endtask : wait_ev

  // ----------------
  // tests
  // ----------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ALL[i]) rd(ALL[i], 32'h0);
    apb(1'b0, 16'h0100, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    apb(1'b1, EN, 32'h3);
    apb(1'b1, MK, 32'hF);
    rd(EN, 32'h3);
    rd(MK, 32'hF);
    plug(1'b1, 1'b0, 1'b0);
    wait_ev(20, 1'b1);
    check("present a", {31'h0, pres_a}, 32'h1);
    plug(1'b1, 1'b1, 1'b0);
    wait_ev(20, 1'b1);
    check("present b", {31'h0, pres_b}, 32'h1);
    rd(S1, 32'h5);
    rd(S2, 32'h5);
    apb(1'b1, MK, 32'h4);
    plug(1'b1, 1'b0, 1'b0);
    wait_ev(20, 1'b0);
    plug(1'b0, 1'b0, 1'b0);
    wait_ev(20, 1'b1);
    apb(1'b1, EN, 32'h2);
    apb(1'b1, MK, 32'hF);
    plug(1'b1, 1'b0, 1'b0);
    wait_ev(20, 1'b0);
    rd(S2, 32'h0);
    apb(1'b1, EN, 32'h3);
    wait_ev(20, 1'b0);
    rd(S1, 32'h1);
    apb(1'b1, EN, 32'h2);
    plug(1'b0, 1'b0, 1'b0);
    wait_ev(20, 1'b0);
    apb(1'b1, EN, 32'h3);
    apb(1'b1, DB, 32'h5);
    rd(DB, 32'h5);
    plug(1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge pclk);
    bounce <= 1'b0;
    wait_ev(40, 1'b0);
    wait_ev(20000, 1'b1);
    check("filtered a", {31'h0, pres_a}, 32'h1);
    @(posedge pclk);
    sleep <= 1'b1;
    plug(1'b0, 1'b0, 1'b0);
    wait_ev(20, 1'b1);
    check("removed a", {31'h0, pres_a}, 32'h0);
    final_report();
  end
endmodule : jack_insertion_detect_tb
`default_nettype wire
